// ===== design/idma_pkg.sv
// shared constants and types of the indirect data memory access unit
package idma_pkg;
	// special-function locations in sector 0, word index on the bus
	localparam logic [7:0] OFF_PORT0    = 8'h00;
	localparam logic [7:0] OFF_SEC0_PTR = 8'h01;
	localparam logic [7:0] OFF_PORT1    = 8'h02;
	localparam logic [7:0] OFF_PTR1_LO  = 8'h03;
	localparam logic [7:0] OFF_PTR1_HI  = 8'h04;
	localparam logic [7:0] OFF_PORT2    = 8'h0C;
	localparam logic [7:0] OFF_PTR2_LO  = 8'h0D;
	localparam logic [7:0] OFF_PTR2_HI  = 8'h0E;

	// offsets below this limit form the special-function area
	localparam logic [7:0] SFR_LIMIT = 8'h80;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// pointer storage slots
	localparam int NUM_PTRS = 5;
	localparam logic [2:0] PTR_SEC0   = 3'h0;
	localparam logic [2:0] PTR_P1_LO  = 3'h1;
	localparam logic [2:0] PTR_P1_HI  = 3'h2;
	localparam logic [2:0] PTR_P2_LO  = 3'h3;
	localparam logic [2:0] PTR_P2_HI  = 3'h4;

	// bus word holds one data byte in its low lane
	localparam int LANE_BITS = 2;

	// what a bus access finally lands on
	typedef enum logic [2:0] {
		KIND_NONE = 3'b001,
		KIND_MEM  = 3'b010,
		KIND_PTR  = 3'b100
	} idma_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_ACK   = 3'b100
	} idma_state_t;
endpackage : idma_pkg

// ===== design/idma_mem.sv
// general-purpose data memory with registered read data
`timescale 1ns/1ps
module idma_mem #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 9
) (
	input  wire logic              ref_clk_in,
	input  wire logic              rst_in,
	input  wire logic              wr_en_in,
	input  wire logic              rd_en_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	output logic      [DATA_W-1:0] rdata_out
);
	logic [DATA_W-1:0] store [2**ADDR_W];

	// array has no reset: contents are undefined until written
	always_ff @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			store[addr_in] <= wdata_in;
		end
	end

	// read port is registered, one cycle after the enable
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= '0;
		end else if (rd_en_in) begin
			rdata_out <= store[addr_in];
		end
	end
endmodule : idma_mem

// ===== design/idma_resolve.sv
// resolves a data memory address to storage, pointer or nothing
`timescale 1ns/1ps
module idma_resolve #(
	parameter int SECTOR_BITS = 2,
	parameter int NUM_SECTORS = 3
) (
	input  wire logic [SECTOR_BITS+7:0] word_in,
	input  wire logic [7:0]             sec0_ptr_in,
	input  wire logic [7:0]             ptr1_lo_in,
	input  wire logic [7:0]             ptr1_hi_in,
	input  wire logic [7:0]             ptr2_lo_in,
	input  wire logic [7:0]             ptr2_hi_in,
	output idma_pkg::idma_kind_t        kind_out,
	output logic [SECTOR_BITS+6:0]      mem_addr_out,
	output logic [2:0]                  ptr_sel_out
);
	logic [7:0] eff_sector;
	logic [7:0] eff_offset;

	// a port redirects exactly once; no chained indirection
	always_comb begin
		eff_sector = 8'(word_in[SECTOR_BITS+7:8]);
		eff_offset = word_in[7:0];
		if (word_in[SECTOR_BITS+7:8] == '0) begin
			case (word_in[7:0])
			idma_pkg::OFF_PORT0: begin
				eff_sector = 8'h00;
				eff_offset = sec0_ptr_in;
			end
			idma_pkg::OFF_PORT1: begin
				eff_sector = ptr1_hi_in;
				eff_offset = ptr1_lo_in;
			end
			idma_pkg::OFF_PORT2: begin
				eff_sector = ptr2_hi_in;
				eff_offset = ptr2_lo_in;
			end
			default: begin
			end
			endcase
		end
	end

	// classify; ports, unused locations and absent sectors hit nothing
	always_comb begin
		kind_out     = idma_pkg::KIND_NONE;
		mem_addr_out = {eff_sector[SECTOR_BITS-1:0], eff_offset[6:0]};
		ptr_sel_out  = idma_pkg::PTR_SEC0;
		if (eff_sector < 8'(NUM_SECTORS)) begin
			if (eff_offset >= idma_pkg::SFR_LIMIT) begin
				kind_out = idma_pkg::KIND_MEM;
			end else if (eff_sector == 8'h00) begin
				kind_out = idma_pkg::KIND_PTR;
				case (eff_offset)
				idma_pkg::OFF_SEC0_PTR: ptr_sel_out = idma_pkg::PTR_SEC0;
				idma_pkg::OFF_PTR1_LO:  ptr_sel_out = idma_pkg::PTR_P1_LO;
				idma_pkg::OFF_PTR1_HI:  ptr_sel_out = idma_pkg::PTR_P1_HI;
				idma_pkg::OFF_PTR2_LO:  ptr_sel_out = idma_pkg::PTR_P2_LO;
				idma_pkg::OFF_PTR2_HI:  ptr_sel_out = idma_pkg::PTR_P2_HI;
				default: kind_out = idma_pkg::KIND_NONE;
				endcase
			end
		end
	end
endmodule : idma_resolve

// ===== design/idma_top.sv
// indirect data memory access unit behind an Avalon-MM slave
//
// Behaviour
// - port accesses act on the pointed location
// - first port reaches sector 0 only
// - paired-pointer ports reach every sector
// - reading a port itself returns 00H
// - writing a port itself changes nothing
// - unused special-function locations read 00H
// - high byte picks sector, low picks location
// - pointers are plain readable writable registers
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module idma_top #(
	parameter int SECTOR_BITS = 2,
	parameter int NUM_SECTORS = 3,
	parameter int AVS_ADDR_W  = SECTOR_BITS + 10
) (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_in,
	input  wire logic [AVS_ADDR_W-1:0] avs_address_in,
	input  wire logic                  avs_read_in,
	input  wire logic                  avs_write_in,
	input  wire logic [31:0]           avs_writedata_in,
	input  wire logic [3:0]            avs_byteenable_in,
	output logic      [31:0]           avs_readdata_out,
	output logic                       avs_waitrequest_out
);
	localparam int WORD_W = SECTOR_BITS + 8;
	localparam int MEM_W  = SECTOR_BITS + 7;

	idma_pkg::idma_state_t state;
	idma_pkg::idma_state_t next_state;
	idma_pkg::idma_kind_t  kind;
	idma_pkg::idma_kind_t  kind_q;
	idma_pkg::idma_kind_t  next_kind;

	logic [WORD_W-1:0] word;
	logic [MEM_W-1:0]  mem_addr;
	logic [2:0]        ptr_sel;
	logic [2:0]        sel_q;
	logic [2:0]        next_sel;
	logic [7:0]        wbyte;
	logic [7:0]        readdata_q;
	logic [7:0]        next_readdata;
	logic [7:0]        mem_rdata;
	logic              mem_wr;
	logic              mem_rd;
	logic              ptr_wr;
	logic              idle;
	logic [7:0]        ptr_q    [idma_pkg::NUM_PTRS];
	logic [7:0]        next_ptr [idma_pkg::NUM_PTRS];

	// the low two address bits pick a byte lane; data lives in lane 0
	assign word  = avs_address_in[AVS_ADDR_W-1:idma_pkg::LANE_BITS];
	assign wbyte = avs_writedata_in[7:0];
	assign idle  = (state == idma_pkg::ST_IDLE);

	idma_resolve #(
		.SECTOR_BITS (SECTOR_BITS),
		.NUM_SECTORS (NUM_SECTORS)
	) u_resolve (
		.word_in      (word),
		.sec0_ptr_in  (ptr_q[idma_pkg::PTR_SEC0]),
		.ptr1_lo_in   (ptr_q[idma_pkg::PTR_P1_LO]),
		.ptr1_hi_in   (ptr_q[idma_pkg::PTR_P1_HI]),
		.ptr2_lo_in   (ptr_q[idma_pkg::PTR_P2_LO]),
		.ptr2_hi_in   (ptr_q[idma_pkg::PTR_P2_HI]),
		.kind_out     (kind),
		.mem_addr_out (mem_addr),
		.ptr_sel_out  (ptr_sel)
	);

	// storage strobes fire once, in the idle cycle that takes the request
	always_comb begin
		mem_wr = idle && avs_write_in && avs_byteenable_in[0]
			&& (kind == idma_pkg::KIND_MEM);
		mem_rd = idle && avs_read_in
			&& (kind == idma_pkg::KIND_MEM);
		ptr_wr = idle && avs_write_in && avs_byteenable_in[0]
			&& (kind == idma_pkg::KIND_PTR);
	end

	idma_mem #(
		.DATA_W (8),
		.ADDR_W (MEM_W)
	) u_mem (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.wr_en_in   (mem_wr),
		.rd_en_in   (mem_rd),
		.addr_in    (mem_addr),
		.wdata_in   (wbyte),
		.rdata_out  (mem_rdata)
	);

	// access sequencer: reads need a fetch cycle for the memory latency
	always_comb begin
		next_state    = state;
		next_kind     = kind_q;
		next_sel      = sel_q;
		next_readdata = readdata_q;
		case (state)
		idma_pkg::ST_IDLE: begin
			if (avs_read_in) begin
				next_state = idma_pkg::ST_FETCH;
				next_kind  = kind;
				next_sel   = ptr_sel;
			end else if (avs_write_in) begin
				next_state = idma_pkg::ST_ACK;
			end
		end
		idma_pkg::ST_FETCH: begin
			next_state = idma_pkg::ST_ACK;
			case (kind_q)
			idma_pkg::KIND_MEM: next_readdata = mem_rdata;
			idma_pkg::KIND_PTR: next_readdata = ptr_q[sel_q];
			default: next_readdata = idma_pkg::ZERO_BYTE;
			endcase
		end
		idma_pkg::ST_ACK: begin
			next_state = idma_pkg::ST_IDLE;
		end
		default: begin
			next_state = idma_pkg::ST_IDLE;
		end
		endcase
	end

	// sequencer registers
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state      <= idma_pkg::ST_IDLE;
			kind_q     <= idma_pkg::KIND_NONE;
			sel_q      <= idma_pkg::PTR_SEC0;
			readdata_q <= idma_pkg::ZERO_BYTE;
		end else begin
			state      <= next_state;
			kind_q     <= next_kind;
			sel_q      <= next_sel;
			readdata_q <= next_readdata;
		end
	end

	// pointer next values; an indirect write may land on a pointer too
	always_comb begin
		for (int i = 0; i < idma_pkg::NUM_PTRS; i++) begin
			next_ptr[i] = ptr_q[i];
		end
		if (ptr_wr) begin
			next_ptr[ptr_sel] = wbyte;
		end
	end

	// one register per pointer byte
	for (genvar g = 0; g < idma_pkg::NUM_PTRS; g++) begin : g_ptr
		always_ff @(posedge ref_clk_in or posedge rst_in) begin
			if (rst_in) begin
				ptr_q[g] <= idma_pkg::PTR_RESET;
			end else begin
				ptr_q[g] <= next_ptr[g];
			end
		end
	end

	// answer only from the ack state, so waitrequest is high in reset
	assign avs_waitrequest_out = (state != idma_pkg::ST_ACK);
	assign avs_readdata_out    = 32'(readdata_q);

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	// every read is answered on the second edge after it is taken
	read_answer_a: assert property (
		(idle && avs_read_in) |-> avs_waitrequest_out
			##1 avs_waitrequest_out ##1 !avs_waitrequest_out
	) else $error("read not answered after two cycles");

	// a write is answered on the next edge
	write_answer_a: assert property (
		(idle && avs_write_in) |-> avs_waitrequest_out
			##1 !avs_waitrequest_out
	) else $error("write not answered after one cycle");

	// first port pointing at itself reads as zero
	port_self_zero_a: assert property (
		(idle && avs_read_in
			&& word == WORD_W'(idma_pkg::OFF_PORT0)
			&& ptr_q[idma_pkg::PTR_SEC0] == idma_pkg::OFF_PORT0)
		|-> ##2 (avs_readdata_out == 32'h00000000)
	) else $error("self-referencing port read not zero");

	// second port aimed at the third port leaves all storage alone
	port_write_void_a: assert property (
		(idle && avs_write_in
			&& word == WORD_W'(idma_pkg::OFF_PORT1)
			&& ptr_q[idma_pkg::PTR_P1_HI] == idma_pkg::ZERO_BYTE
			&& ptr_q[idma_pkg::PTR_P1_LO] == idma_pkg::OFF_PORT2)
		|-> !mem_wr && !ptr_wr ##1 ($stable(ptr_q[0])
			&& $stable(ptr_q[1]) && $stable(ptr_q[2])
			&& $stable(ptr_q[3]) && $stable(ptr_q[4]))
	) else $error("write to a port location changed storage");

	// first port never leaves sector 0
	sector0_only_a: assert property (
		((mem_wr || mem_rd) && word == WORD_W'(idma_pkg::OFF_PORT0))
		|-> (mem_addr[MEM_W-1:7] == '0)
	) else $error("first port reached beyond sector 0");

	// second port address built from its pointer pair
	pair_sector_a: assert property (
		((mem_wr || mem_rd) && word == WORD_W'(idma_pkg::OFF_PORT1))
		|-> (mem_addr == {ptr_q[idma_pkg::PTR_P1_HI][SECTOR_BITS-1:0],
			ptr_q[idma_pkg::PTR_P1_LO][6:0]})
	) else $error("second port address not from its pointers");

	// third port writes its byte at the pointed location
	port_write_a: assert property (
		(idle && avs_write_in && avs_byteenable_in[0]
			&& word == WORD_W'(idma_pkg::OFF_PORT2)
			&& kind == idma_pkg::KIND_MEM)
		|-> mem_wr && (mem_addr ==
			{ptr_q[idma_pkg::PTR_P2_HI][SECTOR_BITS-1:0],
			ptr_q[idma_pkg::PTR_P2_LO][6:0]})
	) else $error("third port write missed its target");

	// anything that resolves to nothing reads as zero
	unused_zero_a: assert property (
		(idle && avs_read_in && kind == idma_pkg::KIND_NONE)
		|-> ##2 (!avs_waitrequest_out
			&& avs_readdata_out == 32'h00000000)
	) else $error("unused location did not read zero");

	// a direct write loads the sector 0 pointer
	ptr_load_a: assert property (
		(idle && avs_write_in && avs_byteenable_in[0]
			&& word == WORD_W'(idma_pkg::OFF_SEC0_PTR))
		|=> (ptr_q[idma_pkg::PTR_SEC0] == $past(wbyte))
	) else $error("sector 0 pointer not loaded");

	// a direct read returns the high pointer byte
	ptr_readback_a: assert property (
		(idle && avs_read_in
			&& word == WORD_W'(idma_pkg::OFF_PTR1_HI))
		|-> ##2 (avs_readdata_out[7:0] == $past(ptr_q[2], 2))
	) else $error("pointer read back wrong");

	// waitrequest drops for a single cycle per access
	wait_single_a: assert property (
		!avs_waitrequest_out |=> avs_waitrequest_out
	) else $error("waitrequest low for more than one cycle");

	// read data hold until the next read finishes its fetch
	readdata_hold_a: assert property (
		(state != idma_pkg::ST_FETCH) |=> $stable(readdata_q)
	) else $error("read data changed outside a fetch");

	// a held write request must not store twice
	mem_write_once_a: assert property (
		mem_wr |=> !mem_wr
	) else $error("memory written twice by one request");

	// stored bytes come back through the registered read port
	mem_read_data_a: assert property (
		(idle && avs_read_in && kind == idma_pkg::KIND_MEM)
		|-> ##2 (avs_readdata_out[7:0] == $past(mem_rdata))
	) else $error("memory read data lost");

	// first port writes land in sector 0 whatever the pairs hold
	port0_write_a: assert property (
		(idle && avs_write_in && avs_byteenable_in[0]
			&& word == WORD_W'(idma_pkg::OFF_PORT0)
			&& ptr_q[idma_pkg::PTR_SEC0] >= idma_pkg::SFR_LIMIT)
		|-> mem_wr && (mem_addr == {{SECTOR_BITS{1'b0}},
			ptr_q[idma_pkg::PTR_SEC0][6:0]})
	) else $error("first port write left sector 0");

	// first port aimed at itself stores nothing
	port0_write_void_a: assert property (
		(idle && avs_write_in && word == WORD_W'(idma_pkg::OFF_PORT0)
			&& ptr_q[idma_pkg::PTR_SEC0] == idma_pkg::OFF_PORT0)
		|-> !mem_wr && !ptr_wr
	) else $error("self-referencing port write stored data");

	// second port aimed at the third port reads as zero
	port1_self_zero_a: assert property (
		(idle && avs_read_in && word == WORD_W'(idma_pkg::OFF_PORT1)
			&& ptr_q[idma_pkg::PTR_P1_HI] == idma_pkg::ZERO_BYTE
			&& ptr_q[idma_pkg::PTR_P1_LO] == idma_pkg::OFF_PORT2)
		|-> ##2 (avs_readdata_out == 32'h00000000)
	) else $error("port aimed at a port did not read zero");

	// third port reads from the location its pair selects
	port2_read_a: assert property (
		(idle && avs_read_in && word == WORD_W'(idma_pkg::OFF_PORT2)
			&& kind == idma_pkg::KIND_MEM)
		|-> mem_rd && (mem_addr == {ptr_q[idma_pkg::PTR_P2_HI][SECTOR_BITS-1:0],
			ptr_q[idma_pkg::PTR_P2_LO][6:0]})
	) else $error("third port read missed its target");

	// a write that resolves to nothing leaves every pointer alone
	unused_write_void_a: assert property (
		(idle && avs_write_in && kind == idma_pkg::KIND_NONE)
		|=> ($stable(ptr_q[0]) && $stable(ptr_q[1])
			&& $stable(ptr_q[2]) && $stable(ptr_q[3])
			&& $stable(ptr_q[4]))
	) else $error("write to nothing changed a pointer");

	// a direct read returns the low byte of the second pair
	ptr2_readback_a: assert property (
		(idle && avs_read_in && word == WORD_W'(idma_pkg::OFF_PTR2_LO))
		|-> ##2 (avs_readdata_out[7:0]
			== $past(ptr_q[idma_pkg::PTR_P2_LO], 2))
	) else $error("pair low byte read back wrong");
endmodule : idma_top

// ===== testbench/idma_core_model.sv
// core-side bus master model issuing data memory accesses
`timescale 1ns/1ps
module idma_core_model (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic [31:0] avs_readdata_in,
	input  wire logic        avs_waitrequest_in,
	output logic      [11:0] avs_address_out,
	output logic             avs_read_out,
	output logic             avs_write_out,
	output logic      [31:0] avs_writedata_out,
	output logic      [3:0]  avs_byteenable_out
);
	// bus idle from time zero
	initial begin
		avs_address_out = 12'h000;
		avs_read_out = 1'b0;
		avs_write_out = 1'b0;
		avs_writedata_out = 32'h00000000;
		avs_byteenable_out = 4'hF;
	end

	// byte lanes for the following writes; only lane 0 carries data
	task automatic set_lanes(input logic [3:0] be);
		avs_byteenable_out <= be;
	endtask : set_lanes

	// one access, held until waitrequest is seen low; ok low on timeout
	task automatic access(input logic rd, input logic [9:0] loc,
		input logic [7:0] data, output logic ok);
		int n;
		ok = 1'b0;
		@(posedge ref_clk_in);
		avs_address_out <= {loc, 2'b00};
		avs_read_out <= rd;
		avs_write_out <= !rd;
		avs_writedata_out <= {24'h000000, data};
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge ref_clk_in);
			ok = (avs_waitrequest_in === 1'b0);
		end
		// release only after the accepting edge
		avs_read_out <= 1'b0;
		avs_write_out <= 1'b0;
	endtask : access
endmodule : idma_core_model

// ===== testbench/tb.sv
// self-checking bench for the indirect data memory access unit
`timescale 1ns/1ps
module tb;
	logic        ref_clk_in;
	logic        rst_in;
	logic [11:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h67BB;
	int          bad_count = 0;
	int          cmp_count = 0;
	logic [9:0]  ptr_loc [5] = '{10'h001, 10'h003, 10'h004, 10'h00D, 10'h00E};
	logic [9:0]  unused_loc [5] = '{10'h005, 10'h07F, 10'h101, 10'h240,
		10'h3A0};

	idma_top dut (
		.ref_clk_in          (ref_clk_in),
		.rst_in              (rst_in),
		.avs_address_in      (avs_address),
		.avs_read_in         (avs_read),
		.avs_write_in        (avs_write),
		.avs_writedata_in    (avs_writedata),
		.avs_byteenable_in   (avs_byteenable),
		.avs_readdata_out    (avs_readdata),
		.avs_waitrequest_out (avs_waitrequest)
	);

	idma_core_model core (
		.ref_clk_in         (ref_clk_in),
		.rst_in             (rst_in),
		.avs_readdata_in    (avs_readdata),
		.avs_waitrequest_in (avs_waitrequest),
		.avs_address_out    (avs_address),
		.avs_read_out       (avs_read),
		.avs_write_out      (avs_write),
		.avs_writedata_out  (avs_writedata),
		.avs_byteenable_out (avs_byteenable)
	);

	// free-running 100 MHz clock
	initial ref_clk_in = 1'b0;
	always #5 ref_clk_in = ~ref_clk_in;

	// xorshift source so runs repeat exactly
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic end_sim();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [9:0] loc, input logic [7:0] d);
		logic ok;
		core.access(1'b0, loc, d, ok);
		if (!ok) begin
			bad_count++;
			end_sim();
		end
	endtask : wr

	// notes the expected byte, then reads; the monitor compares
	task automatic rd(input logic [9:0] loc, input logic [7:0] e);
		logic ok;
		exp_q.push_back({24'h000000, e});
		core.access(1'b1, loc, 8'h00, ok);
		if (!ok) begin
			bad_count++;
			end_sim();
		end
	endtask : rd

	// read data stand only at the edge where waitrequest is low
	always @(posedge ref_clk_in) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0) begin
				check("unexpected read", 32'h1, 32'h0);
			end else begin
				check("read data", avs_readdata, exp_q.pop_front());
			end
		end
	end

	initial begin
		int         s;
		logic [7:0] v [5];
		logic [7:0] d;
		rst_in = 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		// pointers start cleared and behave as plain storage
		foreach (ptr_loc[i]) rd(ptr_loc[i], 8'h00);
		foreach (ptr_loc[i]) begin
			v[i] = rnd();
			wr(ptr_loc[i], v[i]);
		end
		foreach (ptr_loc[i]) rd(ptr_loc[i], v[i]);
		// first port stays in sector 0 though the pair selects sector 2
		wr(10'h2A5, 8'h3C);
		wr(10'h004, 8'h02);
		wr(10'h001, 8'hA5);
		d = rnd();
		wr(10'h000, d);
		rd(10'h0A5, d);
		rd(10'h2A5, 8'h3C);
		rd(10'h000, d);
		rd(10'h001, 8'hA5);
		// a write with lane 0 off is acknowledged but stores nothing
		core.set_lanes(4'hE);
		wr(10'h0A5, ~d);
		core.set_lanes(4'hF);
		rd(10'h0A5, d);
		// paired ports reach every sector, high byte picks the sector
		for (s = 0; s < 3; s++) begin
			d = rnd();
			wr(10'h004, s[7:0]);
			wr(10'h003, 8'h90 | s[7:0]);
			wr(10'h002, d);
			rd({s[1:0], 8'h90 | s[7:0]}, d);
			wr(10'h00E, s[7:0]);
			wr(10'h00D, 8'hC0);
			wr({s[1:0], 8'hC0}, ~d);
			rd(10'h00C, ~d);
		end
		// a port aimed at a port reads zero and stores nothing
		wr(10'h004, 8'h00);
		wr(10'h003, 8'h0C);
		rd(10'h002, 8'h00);
		wr(10'h002, 8'h5A);
		rd(10'h00E, 8'h02);
		rd(10'h00D, 8'hC0);
		wr(10'h001, 8'h00);
		rd(10'h000, 8'h00);
		wr(10'h000, 8'h77);
		rd(10'h001, 8'h00);
		rd(10'h003, 8'h0C);
		// unused special locations and absent-sector locations ignore writes and read zero
		foreach (unused_loc[i]) begin
			wr(unused_loc[i], rnd());
			rd(unused_loc[i], 8'h00);
		end
		@(posedge ref_clk_in);
		check("pending reads", 32'(exp_q.size()), 32'h0);
		end_sim();
	end
endmodule : tb
